// [rtl/spfc_regs.svh]
/*
  Register offsets, field positions, reset values and bit-rate counts
  of the serial port control block.
  Assumes an APB slave with 32-bit data and byte addresses.
*/
`ifndef SPFC_REGS_SVH
`define SPFC_REGS_SVH

// byte offsets
`define SPFC_OFS_CTRL   8'h00
`define SPFC_OFS_AUX    8'h04
`define SPFC_OFS_SLAVE_ADDRESS  8'h08
`define SPFC_OFS_SMASK  8'h0C
`define SPFC_OFS_DATA   8'h10
`define SPFC_OFS_DIV    8'h14
`define SPFC_OFS_IST    8'h18
`define SPFC_OFS_ICLR   8'h1C
`define SPFC_OFS_IEN    8'h20

// serial_control fields
`define SPFC_SC_MSH     7
`define SPFC_SC_MSL     6
`define SPFC_SC_FILT    5
`define SPFC_SC_REN     4
`define SPFC_SC_TB8     3
`define SPFC_SC_RB8     2
`define SPFC_SC_TI      1
`define SPFC_SC_RI      0

// aux fields
`define SPFC_AUX_FES    0
`define SPFC_AUX_X6     1
`define SPFC_AUX_DBL    2

// event bits of status, clear and enable
`define SPFC_EV_RX      0
`define SPFC_EV_TX      1
`define SPFC_EV_FE      2

// reset values
`define SPFC_RST_DIV    16'h0010

// bit periods in mclk cycles (mclk is the oscillator)
`define SPFC_M0_SLOW    16'h000C
`define SPFC_M0_FAST    16'h0006
`define SPFC_M2_SLOW    16'h0040
`define SPFC_M2_FAST    16'h0020

`endif

// [rtl/spfc_pkg.sv]
/*
  Types of the serial port control block: bus carriers, engine states
  and the packed state record.
  Assumes nothing beyond the register header.
*/
package spfc_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } spfc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spfc_apb_rsp_t;

  typedef enum logic [0:0] {TX_IDLE, TX_RUN} spfc_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_SHIFT}
    spfc_rx_st_t;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic        fe;
    logic [2:0]  aux;
    logic [7:0]  slave_address;
    logic [7:0]  smask;
    logic [15:0] div;
    logic [7:0]  rxbuf;
    logic [2:0]  sts;
    logic [2:0]  ien;
    logic [31:0] prdata;
    logic        rdy;
    logic        err;
    spfc_tx_st_t tx_st;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_idx;
    logic [3:0]  tx_last;
    logic [10:0] tx_sh;
    spfc_rx_st_t rx_st;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_idx;
    logic [9:0]  rx_sh;
    logic [2:0]  sy;
    logic        rxf;
    logic        rxp;
    logic        txd;
    logic        rxd_o;
    logic        rxd_oe_n;
  } spfc_state_t;

endpackage

// [rtl/spfc_serial_port.sv]
/*
  Serial port control block: mode select, shift-register and UART
  engines, multiprocessor address filter, completion flags and an
  APB register slave with a level interrupt.
  Assumes mclk is the oscillator clock, rxd_i is asynchronous and the
  rxd pad is resolved outside from rxd_o and rxd_oe_n.
*/
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "spfc_regs.svh"

module spfc_serial_port (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // register bus
  input  wire spfc_pkg::spfc_apb_req_t apb_req,
  output spfc_pkg::spfc_apb_rsp_t      apb_rsp,
  // serial pins
  output logic                        txd,
  input  wire logic                   rxd_i,
  output logic                        rxd_o,
  output logic                        rxd_oe_n,
  // interrupts
  output logic                        irq,
  output logic                        serial_req
);

  spfc_pkg::spfc_state_t q;
  spfc_pkg::spfc_state_t n;

  logic [1:0]  mode;
  logic        nine;
  logic [15:0] per;
  logic [15:0] half;
  logic        setup;
  logic        acc;
  logic        wr;
  logic [7:0]  wb;
  logic        tx_go;
  logic [9:0]  nsh;
  logic [7:0]  rx_byte;
  logic        match;
  logic        given_hit;
  logic        bcast_hit;
  logic [31:0] rd_val;
  logic        rd_err;

  assign mode = {q.ctrl[`SPFC_SC_MSH], q.ctrl[`SPFC_SC_MSL]};
  assign nine = mode[1];

  // bit period for the current mode
  always_comb
  begin
    unique case (mode)
      2'b00:   per = q.aux[`SPFC_AUX_X6] ? `SPFC_M0_FAST
                                         : `SPFC_M0_SLOW;
      2'b10:   per = q.aux[`SPFC_AUX_DBL] ? `SPFC_M2_FAST
                                          : `SPFC_M2_SLOW;
      default: per = (q.div == 16'h0000) ? 16'h0001 : q.div;
    endcase
  end

  assign half = (per[15:1] == 15'h0000) ? 16'h0001 : {1'b0, per[15:1]};

  assign setup = apb_req.psel & ~apb_req.penable;
  assign acc   = apb_req.psel & apb_req.penable & q.rdy;
  assign wr    = acc & apb_req.pwrite;
  assign wb    = apb_req.pwdata[7:0];
  assign tx_go = wr & (apb_req.paddr == `SPFC_OFS_DATA)
               & (q.tx_st == spfc_pkg::TX_IDLE)
               & (q.rx_st != spfc_pkg::RX_SHIFT);

  // received frame as it stands after the current sample
  assign nsh     = {q.rxf, q.rx_sh[9:1]};
  assign rx_byte = nine ? nsh[7:0] : nsh[8:1];

  assign given_hit = ((rx_byte ^ q.slave_address) & q.smask) == 8'h00;
  assign bcast_hit = ((~rx_byte) & (q.slave_address | q.smask)) == 8'h00;
  assign match     = given_hit | bcast_hit;

  // read mux, sampled in the setup phase
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (apb_req.paddr)
      `SPFC_OFS_CTRL:
        rd_val[7:0] = {q.aux[`SPFC_AUX_FES] ? q.fe
                                             : q.ctrl[`SPFC_SC_MSH],
                       q.ctrl[6:0]};
      `SPFC_OFS_AUX:   rd_val[2:0]  = q.aux;
      `SPFC_OFS_SLAVE_ADDRESS: rd_val[7:0]  = q.slave_address;
      `SPFC_OFS_SMASK: rd_val[7:0]  = q.smask;
      `SPFC_OFS_DATA:  rd_val[7:0]  = q.rxbuf;
      `SPFC_OFS_DIV:   rd_val[15:0] = q.div;
      `SPFC_OFS_IST:   rd_val[2:0]  = q.sts;
      `SPFC_OFS_ICLR:  rd_val       = 32'h0000_0000;
      `SPFC_OFS_IEN:   rd_val[2:0]  = q.ien;
      default:         rd_err       = 1'b1;
    endcase
  end

  always_comb
  begin
    n = q;

    // bus answer: one wait-free access phase
    n.rdy = setup;
    if (setup)
    begin
      n.prdata = rd_val;
      n.err    = rd_err;
    end

    // software writes first, so hardware sets below win
    if (wr)
    begin
      unique case (apb_req.paddr)
        `SPFC_OFS_CTRL:
        begin
          n.ctrl[6:0] = wb[6:0];
          if (q.aux[`SPFC_AUX_FES])
            n.fe = wb[7];
          else
            n.ctrl[`SPFC_SC_MSH] = wb[7];
        end
        `SPFC_OFS_AUX:   n.aux   = wb[2:0];
        `SPFC_OFS_SLAVE_ADDRESS: n.slave_address = wb;
        `SPFC_OFS_SMASK: n.smask = wb;
        `SPFC_OFS_DIV:   n.div   = apb_req.pwdata[15:0];
        `SPFC_OFS_ICLR:  n.sts   = q.sts & ~wb[2:0];
        `SPFC_OFS_IEN:   n.ien   = wb[2:0];
        default:         n.err   = q.err;
      endcase
    end

    // input synchroniser: change counts when stages two and three agree
    n.sy  = {q.sy[1:0], rxd_i};
    n.rxp = q.rxf;
    if (q.sy[1] == q.sy[2])
      n.rxf = q.sy[2];

    // transmit engine
    if (tx_go)
    begin
      n.tx_st  = spfc_pkg::TX_RUN;
      n.tx_cnt = per;
      n.tx_idx = 4'h0;
      if (mode == 2'b00)
      begin
        n.tx_sh    = {3'b111, wb};
        n.tx_last  = 4'h8;
        n.rxd_o    = wb[0];
        n.rxd_oe_n = 1'b0;
        n.txd      = 1'b0;
      end
      else
      begin
        n.tx_sh   = {1'b1, nine ? q.ctrl[`SPFC_SC_TB8] : 1'b1,
                     wb, 1'b0};
        n.tx_last = nine ? 4'hA : 4'h9;
        n.txd     = 1'b0;
      end
    end
    else if (q.tx_st == spfc_pkg::TX_RUN)
    begin
      if (q.tx_cnt != 16'h0001)
        n.tx_cnt = q.tx_cnt - 16'h0001;
      else
      begin
        n.tx_cnt = per;
        n.tx_idx = q.tx_idx + 4'h1;
        n.tx_sh  = {1'b1, q.tx_sh[10:1]};
        if (mode == 2'b00)
        begin
          n.rxd_o = q.tx_sh[1];
          if (q.tx_idx + 4'h1 == q.tx_last)
          begin
            n.tx_st                = spfc_pkg::TX_IDLE;
            n.rxd_oe_n             = 1'b1;
            n.ctrl[`SPFC_SC_TI]    = 1'b1;
            n.sts[`SPFC_EV_TX]     = 1'b1;
          end
        end
        else if (q.tx_idx == q.tx_last)
          n.tx_st = spfc_pkg::TX_IDLE;
        else if (q.tx_idx + 4'h1 == q.tx_last)
        begin
          n.ctrl[`SPFC_SC_TI] = 1'b1;
          n.sts[`SPFC_EV_TX]  = 1'b1;
        end
      end
      if (mode == 2'b00)
        n.txd = (n.tx_st == spfc_pkg::TX_IDLE) | (n.tx_cnt <= half);
      else
        n.txd = n.tx_sh[0];
    end

    // receive engine
    if (!q.ctrl[`SPFC_SC_REN] && (q.rx_st != spfc_pkg::RX_IDLE))
    begin
      n.rx_st = spfc_pkg::RX_IDLE;
      if (q.rx_st == spfc_pkg::RX_SHIFT)
        n.txd = 1'b1;
    end
    else
    begin
      unique case (q.rx_st)
        spfc_pkg::RX_IDLE:
        begin
          if (q.ctrl[`SPFC_SC_REN])
          begin
            if (mode == 2'b00)
            begin
              if (!q.ctrl[`SPFC_SC_RI] && !tx_go
                  && (q.tx_st == spfc_pkg::TX_IDLE))
              begin
                n.rx_st  = spfc_pkg::RX_SHIFT;
                n.rx_cnt = per;
                n.rx_idx = 4'h0;
                n.txd    = 1'b0;
              end
            end
            else if (q.rxp && !q.rxf)
            begin
              n.rx_st  = spfc_pkg::RX_START;
              n.rx_cnt = half;
            end
          end
        end
        spfc_pkg::RX_START:
        begin
          if (q.rx_cnt != 16'h0001)
            n.rx_cnt = q.rx_cnt - 16'h0001;
          else if (!q.rxf)
          begin
            n.rx_st  = spfc_pkg::RX_BITS;
            n.rx_cnt = per;
            n.rx_idx = 4'h0;
          end
          else
            n.rx_st = spfc_pkg::RX_IDLE;
        end
        spfc_pkg::RX_BITS:
        begin
          if (q.rx_cnt != 16'h0001)
            n.rx_cnt = q.rx_cnt - 16'h0001;
          else
          begin
            n.rx_cnt = per;
            n.rx_idx = q.rx_idx + 4'h1;
            n.rx_sh  = nsh;
            // this sample is the middle of the stop bit
            if (q.rx_idx == (nine ? 4'h9 : 4'h8))
            begin
              n.rx_st = spfc_pkg::RX_IDLE;
              if (!nsh[9])
              begin
                n.fe               = 1'b1;
                n.sts[`SPFC_EV_FE] = 1'b1;
              end
              if (!q.ctrl[`SPFC_SC_RI]
                  && (!q.ctrl[`SPFC_SC_FILT]
                      || (nine ? (nsh[8] && match)
                               : (nsh[9] && match))))
              begin
                n.rxbuf               = rx_byte;
                n.ctrl[`SPFC_SC_RB8]  = nine ? nsh[8] : nsh[9];
                n.ctrl[`SPFC_SC_RI]   = 1'b1;
                n.sts[`SPFC_EV_RX]    = 1'b1;
              end
            end
          end
        end
        spfc_pkg::RX_SHIFT:
        begin
          if (q.rx_cnt != 16'h0001)
            n.rx_cnt = q.rx_cnt - 16'h0001;
          else
          begin
            n.rx_cnt = per;
            n.rx_idx = q.rx_idx + 4'h1;
            n.rx_sh  = nsh;
            if (q.rx_idx == 4'h7)
            begin
              n.rx_st             = spfc_pkg::RX_IDLE;
              n.rxbuf             = nsh[9:2];
              n.ctrl[`SPFC_SC_RI] = 1'b1;
              n.sts[`SPFC_EV_RX]  = 1'b1;
            end
          end
          n.txd = (n.rx_st == spfc_pkg::RX_IDLE) | (n.rx_cnt <= half);
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      q          <= '0;
      q.div      <= `SPFC_RST_DIV;
      q.sy       <= 3'b111;
      q.rxf      <= 1'b1;
      q.rxp      <= 1'b1;
      q.txd      <= 1'b1;
      q.rxd_o    <= 1'b1;
      q.rxd_oe_n <= 1'b1;
    end
    else
      q <= n;
  end

  assign apb_rsp.prdata  = q.prdata;
  assign apb_rsp.pready  = q.rdy & apb_req.penable;
  assign apb_rsp.pslverr = q.err & q.rdy & apb_req.penable;

  assign txd        = q.txd;
  assign rxd_o      = q.rxd_o;
  assign rxd_oe_n   = q.rxd_oe_n;
  assign serial_req = q.ctrl[`SPFC_SC_RI] | q.ctrl[`SPFC_SC_TI];
  assign irq        = |(q.sts & q.ien);

endmodule

// [dv/spfc_serial_port_properties.sv]
/*
  Port checker of the serial port control block, bound to its top.
  Assumes one mclk domain and synchronous active-low nrst.
*/
`timescale 1ns/1ps
`include "spfc_regs.svh"
module spfc_serial_port_chk (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    nrst,
  // register bus
  input wire spfc_pkg::spfc_apb_req_t apb_req,
  input wire spfc_pkg::spfc_apb_rsp_t apb_rsp,
  // pins
  input wire logic                    txd,
  input wire logic                    rxd_i,
  input wire logic                    rxd_o,
  input wire logic                    rxd_oe_n,
  input wire logic                    irq,
  input wire logic                    serial_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic acc;
  logic wr;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr  = acc && apb_req.pwrite;
  sequence shift_go;
    $fell(rxd_oe_n);
  endsequence
  sequence clk_low;
    !txd [*3] ##[1:4] txd;
  endsequence
  chk_zero_wait: assert property (acc |-> apb_rsp.pready)
    else $error("access without ready");
  chk_ready_gate: assert property (!apb_req.penable |-> !apb_rsp.pready)
    else $error("ready outside access");
  chk_bad_addr: assert property
    (acc && apb_req.paddr > `SPFC_OFS_IEN |-> apb_rsp.pslverr)
    else $error("unmapped without error");
  chk_clear_zero: assert property (acc && !apb_req.pwrite &&
    apb_req.paddr == `SPFC_OFS_ICLR |-> apb_rsp.prdata == 32'h0)
    else $error("clear register not zero");
  chk_reset_idle: assert property
    ($rose(nrst) |-> txd && rxd_oe_n && !irq && !serial_req)
    else $error("pins not idle after reset");
  chk_flag_soft: assert property (wr && apb_req.paddr == `SPFC_OFS_CTRL &&
    |apb_req.pwdata[1:0] |-> ##[1:2] serial_req)
    else $error("written flag gives no request");
  chk_mask_off: assert property (wr && apb_req.paddr == `SPFC_OFS_IEN &&
    apb_req.pwdata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("masked interrupt still high");
  chk_shift_start: assert property (shift_go |-> !txd)
    else $error("shift clock not low at start");
  chk_shift_clk: assert property ($fell(txd) && !rxd_oe_n |-> clk_low)
    else $error("shift clock phase wrong");
  chk_shift_done: assert property ($rose(rxd_oe_n) |-> ##[0:1] serial_req)
    else $error("shift end without done flag");
endmodule

bind spfc_serial_port spfc_serial_port_chk chk_u (
  .mclk(mclk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .txd(txd), .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n),
  .irq(irq), .serial_req(serial_req)
);

// [dv/spfc_node.sv]
/*
  Remote serial node on the far side of the serial pins.
  Assumes bit periods in mclk cycles from the caller; line idles high.
*/
`timescale 1ns/1ps
module spfc_node (
  // clock
  input wire logic mclk,
  // serial lines
  input wire logic txd,
  output logic     line
);
  initial line = 1'b1;
  // start, n data bits lsb first, stop
  task automatic send(input logic [8:0] dv, input int n,
                      input logic stp, input int p);
    for (int i = 0; i < n + 2; i++)
    begin
      line <= (i == 0) ? 1'b0 : (i > n) ? stp : dv[i - 1];
      repeat (p) @(posedge mclk);
    end
    line <= 1'b1;
  endtask
  // samples mid-bit; dv[n] is the bit after the data
  task automatic grab(input int n, input int p, output logic [9:0] dv);
    dv = 10'h000;
    @(negedge txd);
    repeat (p / 2) @(posedge mclk);
    for (int i = 0; i <= n; i++)
    begin
      repeat (p) @(posedge mclk);
      dv[i] = txd;
    end
  endtask
endmodule

// [dv/spfc_serial_port_tb.sv]
/*
  Self-checking bench of the serial port control block.
  Assumes the remote node model and the bound port checker.
*/
`timescale 1ns/1ps
`include "spfc_regs.svh"
module spfc_serial_port_tb;
  spfc_pkg::spfc_apb_req_t req;
  spfc_pkg::spfc_apb_rsp_t rsp;

  logic        mclk;
  logic        nrst;
  logic        txd;
  logic        rxd_i;
  logic        rxd_o;
  logic        rxd_oe_n;
  logic        irq;
  logic        serial_req;
  logic        line;
  logic [31:0] rv;
  logic        er;
  logic [9:0]  d;
  logic [18:0] tbl [8];
  int          mismatches;
  int          samples_checked;
  int          k;

  assign rxd_i = rxd_oe_n ? line : rxd_o;

  spfc_serial_port dut_u (
    .mclk(mclk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .txd(txd),
    .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n), .irq(irq),
    .serial_req(serial_req)
  );
  spfc_node node_u (.mclk(mclk), .txd(txd), .line(line));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge mclk);
    req.penable <= 1'b1;
    @(posedge mclk);
    while (rsp.pready !== 1'b1) @(posedge mclk);
    rv = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stop_test();
  end

  initial
  begin
    req = '0;
    nrst = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    // control, byte, ninth, stop, flag expected
    tbl = '{{8'hF0, 8'hC2, 3'b111},
            {8'hF0, 8'hC2, 3'b010},
            {8'hF0, 8'hC4, 3'b110},
            {8'hF0, 8'hFD, 3'b111},
            {8'h50, 8'h3C, 3'b011},
            {8'h70, 8'hC2, 3'b000},
            {8'h70, 8'hC2, 3'b011},
            {8'h40, 8'h3C, 3'b010}};
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    bus(1'b0, `SPFC_OFS_CTRL, 0);
    chk(rv, 0);
    bus(1'b0, `SPFC_OFS_DIV, 0);
    chk(rv, `SPFC_RST_DIV);
    bus(1'b0, 8'h40, 0);
    chk(er, 1'b1);
    bus(1'b1, `SPFC_OFS_CTRL, 32'h3);
    bus(1'b0, `SPFC_OFS_CTRL, 0);
    chk(rv, 32'h3);
    chk(serial_req, 1'b1);
    bus(1'b1, `SPFC_OFS_CTRL, 0);
    chk(serial_req, 1'b0);
    // with the error view on, bit 7 writes the framing flag instead
    bus(1'b1, `SPFC_OFS_AUX, 32'h1);
    bus(1'b1, `SPFC_OFS_CTRL, 32'h80);
    bus(1'b0, `SPFC_OFS_CTRL, 0);
    chk(rv, 32'h80);
    bus(1'b1, `SPFC_OFS_AUX, 0);
    bus(1'b0, `SPFC_OFS_CTRL, 0);
    chk(rv, 0);
    $display("test registers done");
    bus(1'b1, `SPFC_OFS_DIV, 32'h8);
    bus(1'b1, `SPFC_OFS_IEN, 32'h2);
    for (int m = 1; m < 4; m++)
    begin
      bus(1'b1, `SPFC_OFS_CTRL,
          (m == 1) ? 32'h48 : (m == 2) ? 32'h80 : 32'hC8);
      fork
        node_u.grab((m == 1) ? 8 : 9, (m == 2) ? 64 : 8, d);
        bus(1'b1, `SPFC_OFS_DATA, 32'hA5);
      join
      chk(serial_req, 1'b1);
      chk(d[7:0], 8'hA5);
      chk(d[8], m != 2);
      repeat (64) @(posedge mclk);
      bus(1'b0, `SPFC_OFS_IST, 0);
      chk(rv[1], 1'b1);
      chk(irq, 1'b1);
      bus(1'b1, `SPFC_OFS_IEN, 0);
      chk(irq, 1'b0);
      bus(1'b1, `SPFC_OFS_IEN, 32'h2);
      chk(irq, 1'b1);
      bus(1'b1, `SPFC_OFS_ICLR, 32'h7);
      chk(irq, 1'b0);
    end
    bus(1'b1, `SPFC_OFS_AUX, 32'h2);
    bus(1'b1, `SPFC_OFS_CTRL, 0);
    k = 0;
    d = 10'h000;
    fork
      // shift data is taken on each rising shift clock
      for (int i = 0; i < 8; i++)
      begin
        @(posedge txd);
        d[i] = rxd_o;
      end
      begin
        bus(1'b1, `SPFC_OFS_DATA, 32'h5A);
        while (serial_req !== 1'b1)
        begin
          k++;
          @(posedge mclk);
        end
      end
    join
    chk(k > 40 && k < 52, 1'b1);
    chk(d[7:0], 8'h5A);
    $display("test transmit done");
    bus(1'b1, `SPFC_OFS_SLAVE_ADDRESS, 32'hC0);
    bus(1'b1, `SPFC_OFS_SMASK, 32'hFD);
    foreach (tbl[i])
    begin
      bus(1'b1, `SPFC_OFS_CTRL, tbl[i][18:11]);
      node_u.send({tbl[i][2], tbl[i][10:3]}, tbl[i][18] ? 9 : 8,
                  tbl[i][1], 8);
      repeat (8) @(posedge mclk);
      bus(1'b0, `SPFC_OFS_CTRL, 0);
      chk(rv[0], tbl[i][0]);
      if (tbl[i][0])
        chk(rv[2], tbl[i][18] ? tbl[i][2] : tbl[i][1]);
      bus(1'b0, `SPFC_OFS_DATA, 0);
      if (tbl[i][0])
        chk(rv[7:0], tbl[i][10:3]);
    end
    // rx, tx and framing events have all been seen by now
    bus(1'b0, `SPFC_OFS_IST, 0);
    chk(rv[2:0], 3'b111);
    $display("test receive done");
    stop_test();
  end
endmodule
